// [rtl/ddl_pkg.sv]
package ddl_pkg;

  // Serial word framing
  localparam int unsigned WORD_BITS      = 16;
  localparam int unsigned CMD_MSB        = 15;
  localparam int unsigned CMD_LSB        = 12;
  localparam int unsigned DATA_BITS      = 12;

  // Active-edge counter, saturates once the word is complete
  localparam int unsigned CNT_W          = 5;
  localparam logic [4:0]  CNT_ZERO       = 5'h00;
  localparam logic [4:0]  CNT_ONE        = 5'h01;
  localparam logic [4:0]  CNT_LAST_EDGE  = 5'h0f;
  localparam logic [4:0]  CNT_FULL       = 5'h10;

  // Command codes in the top nibble of a word
  localparam logic [3:0]  CMD_WR_A       = 4'h1;
  localparam logic [3:0]  CMD_WR_B       = 4'h2;
  localparam logic [3:0]  CMD_CTRL       = 4'hd;

  // Bits of the data field of a control word
  localparam int unsigned CTRL_RISE_BIT  = 0;
  localparam int unsigned CTRL_DAISY_BIT = 1;

  // Synchroniser lanes and their idle levels
  localparam int unsigned SYN_W          = 4;
  localparam int unsigned SYN_TGL        = 0;
  localparam int unsigned SYN_FRAME      = 1;
  localparam int unsigned SYN_LOAD       = 2;
  localparam int unsigned SYN_CLR        = 3;
  localparam logic [3:0]  SYN_IDLE       = 4'he;

  // Word buffer between the link and the converter registers
  localparam int unsigned FIFO_DEPTH     = 32;

endpackage

// [rtl/ddl_fifo.sv]
`timescale 1ns/1ps
module ddl_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic             wrValid,
  input  wire logic [WIDTH-1:0] wrData,
  output logic                  wrReady,
  output logic                  rdValid,
  output logic      [WIDTH-1:0] rdData,
  input  wire logic             rdReady
);
  // Depth must be a power of two so the pointers wrap by themselves
  localparam int PTR_W = $clog2(DEPTH);
  localparam logic [PTR_W:0] FULL_CNT = (PTR_W+1)'(DEPTH);
  localparam logic [PTR_W:0] CNT_STEP = (PTR_W+1)'(1);
  localparam logic [PTR_W-1:0] PTR_STEP = PTR_W'(1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wrPtr_q;
  logic [PTR_W-1:0] rdPtr_q;
  logic [PTR_W:0]   count_q;
  logic             push;
  logic             pop;

  // Handshake terms
  assign wrReady = (count_q != FULL_CNT);
  assign rdValid = (count_q != '0);
  assign rdData  = mem[rdPtr_q];
  assign push    = wrValid & wrReady;
  assign pop     = rdValid & rdReady;

  // Storage, no reset needed on data
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr_q] <= wrData;
    end
  end

  // Pointers and fill level
  always_ff @(posedge clk) begin
    if (srst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wrPtr_q <= wrPtr_q + PTR_STEP;
      end
      if (pop) begin
        rdPtr_q <= rdPtr_q + PTR_STEP;
      end
      unique case ({push, pop})
        2'b10:   count_q <= count_q + CNT_STEP;
        2'b01:   count_q <= count_q - CNT_STEP;
        default: count_q <= count_q;
      endcase
    end
  end

endmodule

// [rtl/ddl_serial_load_port.sv]
`timescale 1ns/1ps
// Summary of operation
// (RULE1) Each data bit shifts into a 16-bit register on the selected active edge.
// (RULE2) After reset the falling shift clock edge is the active edge.
// (RULE3) A control word can move sampling to the rising shift clock edge.
// (RULE4) A falling load strobe copies input registers to the converter outputs at once; the code copies only after the strobe has crossed the synchroniser.
// (RULE5) Load held low in standalone mode updates outputs when the word completes.
// (RULE6) Load held low in daisy-chain mode updates outputs when frame sync rises.
// (RULE7) Host starts a frame with frame sync low; shifting only while it is low.
// (RULE8) Standalone mode counts active edges and latches the word on the 16th.
// (RULE9) Serial out changes on the edge opposite to the sampling edge.
// (RULE10) Clear low zeroes the input registers and the converter outputs.
// (RULE11) With frame sync high, shift clock edges leave the shift register untouched.
module ddl_serial_load_port
  import ddl_pkg::*;
#(
  parameter int DAC_BITS = ddl_pkg::DATA_BITS
) (
  input  wire logic                clk,
  input  wire logic                srst,
  input  wire logic                shiftClk,
  input  wire logic                frameSyncN,
  input  wire logic                serialIn,
  input  wire logic                loadStrobeN,
  input  wire logic                clearN,
  output logic                     serialOut_q,
  output logic      [DAC_BITS-1:0] dacCodeA_q,
  output logic      [DAC_BITS-1:0] dacCodeB_q,
  output logic                     daisyChain_q,
  output logic                     overrun_q
);
  import ddl_pkg::*;

  // Link side, clocked by the selected shift clock edge
  logic                 riseMode_q;
  logic                 activeClk;
  logic [CNT_W-1:0]     bitCnt_q;
  logic [WORD_BITS-1:0] shift_q;
  logic [WORD_BITS-1:0] shiftNext;
  logic [WORD_BITS-1:0] wordHold_q;
  logic                 wordTgl_q;
  logic                 lastEdge;

  // Core side
  logic [SYN_W-1:0]     syn1_q;
  logic [SYN_W-1:0]     syn2_q;
  logic [SYN_W-1:0]     syn3_q;
  logic [SYN_W-1:0]     filt_q;
  logic [SYN_W-1:0]     filtPrev_q;
  logic [SYN_W-1:0]     filt_d;
  logic                 wordEvt;
  logic                 frameRise;
  logic                 loadFall;
  logic                 loadLow;
  logic                 clrActive;
  logic                 fifoValid;
  logic [WORD_BITS-1:0] fifoData;
  logic                 fifoReady;
  logic                 rdValid;
  logic [WORD_BITS-1:0] rdData;
  logic                 rdReady;
  logic                 pop;
  logic [3:0]           popCmd;
  logic [DAC_BITS-1:0]  popData;
  logic [DAC_BITS-1:0]  inA_q;
  logic [DAC_BITS-1:0]  inB_q;

  // Edge select: the switch always happens just after an active edge, so the
  // mux only cuts that high phase short; the fall it makes acts as an early
  // non-active edge and never as an extra active one
  assign activeClk = riseMode_q ? shiftClk : ~shiftClk;  // [RULE1]

  // Edge counter cleared by frame sync itself, since the clock may be still;
  // reset clears it too, so the first frame never starts from an unknown count
  always_ff @(posedge activeClk or posedge frameSyncN or posedge srst) begin
    if (srst || frameSyncN) begin
      bitCnt_q <= CNT_ZERO;
    end else if (bitCnt_q != CNT_FULL) begin
      bitCnt_q <= bitCnt_q + CNT_ONE;  // [RULE8]
    end
  end

  assign shiftNext = {shift_q[WORD_BITS-2:0], serialIn};
  assign lastEdge  = ~frameSyncN & (bitCnt_q == CNT_LAST_EDGE);

  // Input shift register, enabled only inside a frame
  always_ff @(posedge activeClk or posedge srst) begin
    if (srst) begin
      shift_q <= '0;
    end else if (!frameSyncN) begin  // [RULE7] [RULE11]
      shift_q <= shiftNext;  // [RULE1]
    end
  end

  // Word latch on the 16th active edge, handed over by a toggle
  always_ff @(posedge activeClk or posedge srst) begin
    if (srst) begin
      wordHold_q <= '0;
      wordTgl_q  <= 1'b0;
    end else if (lastEdge) begin
      wordHold_q <= shiftNext;  // [RULE8]
      wordTgl_q  <= ~wordTgl_q;
    end
  end

  // Edge mode lives here because it steers this domain's own clock
  always_ff @(posedge activeClk or posedge srst) begin
    if (srst) begin
      riseMode_q <= 1'b0;  // [RULE2]
    end else if (lastEdge && shiftNext[CMD_MSB:CMD_LSB] == CMD_CTRL) begin
      riseMode_q <= shiftNext[CTRL_RISE_BIT];  // [RULE3]
    end
  end

  // Serial out moves on the opposite edge, giving the next part a full half period
  always_ff @(negedge activeClk or posedge srst) begin
    if (srst) begin
      serialOut_q <= 1'b0;
    end else begin
      serialOut_q <= shift_q[WORD_BITS-1];  // [RULE9]
    end
  end

  // Three-stage synchronisers; first stage feeds only the second
  always_ff @(posedge clk) begin
    if (srst) begin
      syn1_q <= SYN_IDLE;
      syn2_q <= SYN_IDLE;
      syn3_q <= SYN_IDLE;
    end else begin
      syn1_q <= {clearN, loadStrobeN, frameSyncN, wordTgl_q};
      syn2_q <= syn1_q;
      syn3_q <= syn2_q;
    end
  end

  // A lane changes only where the second and third stages agree
  assign filt_d = (~(syn2_q ^ syn3_q) & syn3_q) | ((syn2_q ^ syn3_q) & filt_q);

  always_ff @(posedge clk) begin
    if (srst) begin
      filt_q     <= SYN_IDLE;
      filtPrev_q <= SYN_IDLE;
    end else begin
      filt_q     <= filt_d;
      filtPrev_q <= filt_q;
    end
  end

  // Events seen in the core domain
  assign wordEvt   = filt_q[SYN_TGL] ^ filtPrev_q[SYN_TGL];
  assign frameRise = filt_q[SYN_FRAME] & ~filtPrev_q[SYN_FRAME];
  assign loadFall  = ~filt_q[SYN_LOAD] & filtPrev_q[SYN_LOAD];
  assign loadLow   = ~filt_q[SYN_LOAD];
  assign clrActive = ~filt_q[SYN_CLR];

  // Link words are read only after their event has crossed; by then they are
  // stable, as the hold register waits 16 edges and the shifter waits a frame
  assign fifoValid = daisyChain_q ? frameRise : wordEvt;  // [RULE6] [RULE8]
  assign fifoData  = daisyChain_q ? shift_q : wordHold_q;

  ddl_fifo #(
    .WIDTH (WORD_BITS),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk     (clk),
    .srst    (srst),
    .wrValid (fifoValid),
    .wrData  (fifoData),
    .wrReady (fifoReady),
    .rdValid (rdValid),
    .rdData  (rdData),
    .rdReady (rdReady)
  );

  // Draining stalls during clear so no word slips past it
  assign rdReady = ~clrActive;
  assign pop     = rdValid & rdReady;
  assign popCmd  = rdData[CMD_MSB:CMD_LSB];
  assign popData = rdData[DAC_BITS-1:0];

  // Sticky overrun: the serial link cannot be held off, so a lost word is flagged
  always_ff @(posedge clk) begin
    if (srst) begin
      overrun_q <= 1'b0;
    end else if (fifoValid && !fifoReady) begin
      overrun_q <= 1'b1;
    end
  end

  // Mode selection by control word
  always_ff @(posedge clk) begin
    if (srst) begin
      daisyChain_q <= 1'b0;
    end else if (pop && popCmd == CMD_CTRL) begin
      daisyChain_q <= rdData[CTRL_DAISY_BIT];
    end
  end

  // Input registers
  always_ff @(posedge clk) begin
    if (srst || clrActive) begin
      inA_q <= '0;  // [RULE10]
      inB_q <= '0;
    end else if (pop) begin
      if (popCmd == CMD_WR_A) begin
        inA_q <= popData;
      end
      if (popCmd == CMD_WR_B) begin
        inB_q <= popData;
      end
    end
  end

  // Converter registers: clear first, then strobe edge, then auto update
  always_ff @(posedge clk) begin
    if (srst || clrActive) begin
      dacCodeA_q <= '0;  // [RULE10]
      dacCodeB_q <= '0;
    end else if (loadFall) begin
      dacCodeA_q <= inA_q;  // [RULE4]
      dacCodeB_q <= inB_q;
    end else if (loadLow && pop) begin
      if (popCmd == CMD_WR_A) begin
        dacCodeA_q <= popData;  // [RULE5] [RULE6]
      end
      if (popCmd == CMD_WR_B) begin
        dacCodeB_q <= popData;
      end
    end
  end

  // Checks in the core domain
  sequence autoWriteA;
    pop && popCmd == CMD_WR_A && loadLow && !loadFall && !clrActive;
  endsequence

  sequence loadEdge;
    loadFall && !clrActive;
  endsequence

  a_clear_zeroes: assert property (@(posedge clk) disable iff (srst)  // [RULE10]
    clrActive |=> dacCodeA_q == '0 && dacCodeB_q == '0 && inA_q == '0 && inB_q == '0)
    else $error("clear did not zero registers");

  a_async_load: assert property (@(posedge clk) disable iff (srst)  // [RULE4]
    loadEdge |=> dacCodeA_q == $past(inA_q) && dacCodeB_q == $past(inB_q))
    else $error("load strobe edge did not copy input registers");

  a_auto_update: assert property (@(posedge clk) disable iff (srst)  // [RULE5]
    autoWriteA |=> dacCodeA_q == $past(popData) && inA_q == $past(popData))
    else $error("held load did not update output with word");

  a_output_hold: assert property (@(posedge clk) disable iff (srst)  // [RULE4]
    !loadFall && !pop && !clrActive |=> $stable(dacCodeA_q) && $stable(dacCodeB_q))
    else $error("converter output changed without cause");

  a_word_queued: assert property (@(posedge clk) disable iff (srst)  // [RULE8]
    wordEvt && !daisyChain_q && fifoReady && !clrActive |=> rdValid)
    else $error("completed word not queued");

  a_daisy_frame: assert property (@(posedge clk) disable iff (srst)  // [RULE6]
    frameRise && daisyChain_q && fifoReady |=> rdValid
      && ($past(rdValid) || rdData == $past(shift_q)))
    else $error("frame end not queued in daisy chain");

  // A finished word alone must not be queued in daisy-chain mode
  a_daisy_skip: assert property (@(posedge clk) disable iff (srst)  // [RULE6]
    wordEvt && daisyChain_q && !frameRise && !rdValid |=> !rdValid)
    else $error("daisy chain queued a word before frame end");

  a_overrun_sticky: assert property (@(posedge clk) disable iff (srst)
    overrun_q |=> overrun_q [*2])
    else $error("overrun flag dropped");

  // The link cannot wait, so every refused push must raise the flag
  a_overrun_set: assert property (@(posedge clk) disable iff (srst)
    fifoValid && !fifoReady |=> overrun_q)
    else $error("lost word not flagged");

  a_reset_falling: assert property (@(posedge clk)  // [RULE2]
    srst |=> !riseMode_q)
    else $error("reset did not select falling edge");

  // Checks in the link domain
  a_shift_sample: assert property (@(posedge activeClk) disable iff (srst)  // [RULE1]
    !frameSyncN |=> shift_q[0] == $past(serialIn))
    else $error("data bit not shifted in");

  a_word_latch: assert property (@(posedge activeClk) disable iff (srst)  // [RULE8]
    lastEdge |=> wordHold_q == $past(shiftNext) && wordTgl_q != $past(wordTgl_q))
    else $error("word not latched on last edge");

  a_frame_hold: assert property (@(posedge activeClk) disable iff (srst)  // [RULE11]
    frameSyncN |=> $stable(shift_q))
    else $error("shift register moved outside a frame");

  a_mode_switch: assert property (@(posedge activeClk) disable iff (srst)  // [RULE3]
    lastEdge && shiftNext[CMD_MSB:CMD_LSB] == CMD_CTRL
      |=> riseMode_q == $past(shiftNext[CTRL_RISE_BIT]))
    else $error("control word did not set edge mode");

  a_out_opposite: assert property (@(posedge activeClk) disable iff (srst)  // [RULE9]
    serialOut_q == shift_q[WORD_BITS-1])
    else $error("serial out not set on opposite edge");

endmodule

// [verification/ddl_host_model.sv]
`timescale 1ns/1ps
module ddl_host_model (
  output logic        shiftClk,
  output logic        frameSyncN,
  output logic        serialIn,
  input  wire logic   serialOut_q
);
  logic [15:0] seenOut;

  // Parked so the first edge of a falling-mode frame is the active one
  initial begin
    shiftClk = 1'b1;
    frameSyncN = 1'b1;
    serialIn = 1'b0;
  end

  // One frame at 30 ns per bit, MSB first; data moves on the non-active edge
  task automatic send(input logic [15:0] word, input int nBits, input bit rise,
                      input int holdNs);
    shiftClk = ~rise;  // Parking move happens with the frame closed
    #15;
    frameSyncN = 1'b0;
    for (int i = 0; i < nBits; i++) begin
      serialIn = word[15-i];
      #15;
      seenOut[15-i] = serialOut_q;
      shiftClk = rise;
      #15;
      if (i < nBits - 1) begin
        shiftClk = ~rise;
      end
    end
    #(holdNs);
    frameSyncN = 1'b1;  // Closed before any trailing edge
    serialIn = ~serialIn;  // Released line shows the inverse, no pull
    #600;  // Crossing needs about five core cycles between words
  endtask

  // Stray edges with the frame closed, data wiggling
  task automatic idleEdges(input int n);
    for (int i = 0; i < n; i++) begin
      #15;
      shiftClk = ~shiftClk;
      serialIn = ~serialIn;
    end
  endtask
endmodule

// [verification/dual_dac_serial_load_port_test.sv]
`timescale 1ns/1ps
module dual_dac_serial_load_port_test;
  logic        clk;
  logic        srst;
  logic        loadStrobeN;
  logic        clearN;
  logic        shiftClk;
  logic        frameSyncN;
  logic        serialIn;
  logic        serialOut;
  logic [11:0] dacA;
  logic [11:0] dacB;
  logic        daisy;
  logic        overrun;
  int          badCount = 0;
  int          nTests = 0;

  ddl_serial_load_port #(.DAC_BITS(12)) DUT (.clk(clk), .srst(srst), .shiftClk(shiftClk),
    .frameSyncN(frameSyncN), .serialIn(serialIn), .loadStrobeN(loadStrobeN),
    .clearN(clearN), .serialOut_q(serialOut), .dacCodeA_q(dacA), .dacCodeB_q(dacB),
    .daisyChain_q(daisy), .overrun_q(overrun));
  ddl_host_model HOST (.shiftClk(shiftClk), .frameSyncN(frameSyncN), .serialIn(serialIn),
    .serialOut_q(serialOut));

  // Core clock, 100 ns
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic ticks(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic checkVal(input logic [31:0] got, input logic [31:0] exp);
    nTests++;
    if (got !== exp) begin
      badCount++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Bounded wait, so intermediate codes while draining do not count
  task automatic waitDac(input bit selB, input logic [11:0] exp);
    int k;
    k = 0;
    while ((selB ? dacB : dacA) !== exp && k < 100) begin
      ticks(1);
      k++;
    end
    checkVal({20'h0, selB ? dacB : dacA}, {20'h0, exp});
  endtask

  task automatic giveVerdict();
    $display("checks %0d mismatches %0d", nTests, badCount);
    if (badCount == 0 && nTests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic runStandalone();
    checkVal({6'h0, dacA, dacB, daisy, overrun}, 32'h0);
    HOST.send(16'h1abc, 16, 1'b0, 0);
    waitDac(1'b0, 12'habc);
    HOST.send(16'h2345, 16, 1'b0, 0);
    waitDac(1'b1, 12'h345);
    HOST.idleEdges(6);
    HOST.send(16'h1a5a, 16, 1'b0, 0);
    checkVal({17'h0, HOST.seenOut[14:0]}, 32'h2345);
    waitDac(1'b0, 12'ha5a);
  endtask

  // Ten edges only: no word may come out
  task automatic runShort();
    HOST.send(16'h1fff, 10, 1'b0, 0);
    ticks(20);
    checkVal({20'h0, dacA}, 32'ha5a);
  endtask

  task automatic runStrobe();
    ticks(1);
    loadStrobeN = 1'b1;
    ticks(4);
    HOST.send(16'h1555, 16, 1'b0, 0);
    ticks(20);
    checkVal({20'h0, dacA}, 32'ha5a);
    loadStrobeN = 1'b0;
    waitDac(1'b0, 12'h555);
  endtask

  // Clear stalls the buffer: 33 words overflow it, 32 drain afterwards
  task automatic runFill();
    ticks(1);
    clearN = 1'b0;
    ticks(8);
    checkVal({8'h0, dacA, dacB}, 32'h0);
    for (int i = 0; i < 33; i++) begin
      HOST.send(16'h1100 + 16'(i), 16, 1'b0, 0);
    end
    checkVal({31'h0, overrun}, 32'h1);
    ticks(1);
    clearN = 1'b1;
    waitDac(1'b0, 12'h11f);
  endtask

  task automatic runModes();
    HOST.send(16'hd001, 16, 1'b0, 0);
    HOST.send(16'h1123, 16, 1'b1, 0);
    waitDac(1'b0, 12'h123);
    HOST.send(16'hd003, 16, 1'b1, 0);
    ticks(10);
    checkVal({31'h0, daisy}, 32'h1);
    fork
      HOST.send(16'h2777, 16, 1'b1, 2000);
      begin
        #1800;
        checkVal({20'h0, dacB}, 32'h0);
      end
    join
    waitDac(1'b1, 12'h777);
  endtask

  // Load held low from the start selects automatic update
  initial begin
    srst = 1'b0;
    loadStrobeN = 1'b0;
    clearN = 1'b1;
    #1;
    srst = 1'b1;  // A real rising edge, so the link-side flops see their reset
    ticks(5);
    srst = 1'b0;
    ticks(6);
    runStandalone();
    runShort();
    runStrobe();
    runFill();
    runModes();
    giveVerdict();
  end

  // Watchdog, far above the roughly 60 us the scenarios need
  initial begin
    #2000000;
    badCount++;
    giveVerdict();
  end
endmodule
